/* hw/clk_src_pkg.sv */
// constants for the clock source and pll control block
// assumes a 10 MHz system clock and an axi4-lite register master
// What this block does
// - strap low: usb oscillator feeds system clock and usb pll; high: external pin feeds system
// - strap low: usb oscillator stays on, software disable ignored
// - strap high: oscillator off at reset, starts when both disable bits cleared
// - rtc reference comes from its own 32.768 kHz crystal oscillator
// - rtc oscillator disabled: rtc halted and its register window not serviced
// - six strap pins latched at reset into boot select bits
// - boot enables each peripheral clock only while queried; all off at handoff
// - clock gate, soft reset count and reset control registers provided
// - pll given up to 4 ms to lock after any reprogramming
// - boot assumes external reference frequency from boot select bits five and four
package clk_src_pkg;
  localparam logic [15:0] UsbSysCtrlOffs   = 16'h1c32;
  localparam logic [15:0] GateAOffs        = 16'h1c02;
  localparam logic [15:0] GateBOffs        = 16'h1c03;
  localparam logic [15:0] BootStrapOffs    = 16'h1c34;
  localparam logic [15:0] SoftRstCntOffs   = 16'h1c04;
  localparam logic [15:0] RstCtrlOffs      = 16'h1c05;
  localparam logic [15:0] IdleCfgOffs      = 16'h0001;
  localparam logic [15:0] PllCtrlOffs      = 16'h1c20;
  localparam logic [15:0] ClkStatusOffs    = 16'h1c21;
  localparam logic [15:0] RtcWinLo         = 16'h1900;
  localparam logic [15:0] RtcWinHi         = 16'h197f;
  localparam int          UsbOscDisPos     = 0;
  localparam int          UsbOscBiasDisPos = 1;
  localparam logic [15:0] UsbSysCtrlReset  = 16'h0003;
  localparam logic [15:0] GateReset        = 16'hffff;
  localparam logic [15:0] IdleReset        = 16'h0000;
  localparam int          ClkHz            = 10_000_000;
  localparam int          LockTimeMs       = 4;
  localparam int          LockCycles       = ClkHz / 1000 * LockTimeMs;
  localparam logic [1:0]  AxiOkay          = 2'b00;
  localparam logic [1:0]  AxiSlvErr        = 2'b10;
  typedef enum logic [1:0] {
    PllBypass  = 2'b00,
    PllLocking = 2'b01,
    PllRunning = 2'b10
  } pll_state_t;
endpackage

/* hw/lock_timer.sv */
// lock interval counter for the pll
// assumes restart is a one-cycle pulse on clk_sys
`timescale 1ns/1ps
`default_nettype none
module lock_timer
  import clk_src_pkg::*;
#(
  parameter int Cycles = LockCycles
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic restart,
  output logic      done
);
  localparam int W = $clog2(Cycles + 1);
  logic [W-1:0] cnt_reg;

  // refused at elaboration: a zero count would let the pll output be used with no lock wait
  if (Cycles < 1) begin : g_count_check
    $error("lock count must be at least one");
  end

  // restart wins so a reprogram mid-count begins the full interval again
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (restart) begin
      cnt_reg <= W'(Cycles);
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - W'(1);
    end
  end

  assign done = (cnt_reg == '0);

  lock_count_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    restart |=> !done) else $error("lock done too early");
endmodule
`default_nettype wire

/* hw/clk_src_ctrl.sv */
// clock source selection, pll lock sequencing, gating and boot strap latch
// assumes an axi4-lite master with one outstanding access per direction
`timescale 1ns/1ps
`default_nettype none
module clk_src_ctrl
  import clk_src_pkg::*;
#(
  parameter int LockCount = LockCycles
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        refSelStrap,
  input  wire logic [5:0]  bootStrapPins,
  input  wire logic        rtcOscPresent,
  input  wire logic [15:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [15:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             usbOscEnable,
  output logic             sysRefFromUsbOsc,
  output logic             sysClkFromPll,
  output logic             pllLocked,
  output logic [1:0]       extRefFreqSel,
  output logic             rtcEnable,
  output logic             rtcSelect,
  output logic [31:0]      periphClkEnable,
  output logic [15:0]      periphResetAsserted,
  output logic [15:0]      idleDomains
);
  logic        strapSeen_reg;
  logic        refSel_reg;
  logic [5:0]  bootSel_reg;
  logic [15:0] usbCtrl_reg;
  logic [15:0] gateA_reg;
  logic [15:0] gateB_reg;
  logic [15:0] softCnt_reg;
  logic [15:0] rstCtrl_reg;
  logic [15:0] idle_reg;
  logic [15:0] pllCtrl_reg;
  logic [15:0] rstTimer_reg;
  logic [15:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic        awHave_reg;
  logic        wHave_reg;
  pll_state_t  pll_reg;
  pll_state_t  pll_next;
  logic        lockDone;
  logic        pllRestart;
  logic        doWrite;
  logic        rtcHit;
  logic        rdErr;
  logic [15:0] rdVal;

  // straps sampled on the first clock after release; reset takes constants only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      strapSeen_reg <= 1'b0;
      refSel_reg    <= 1'b0;
      bootSel_reg   <= 6'h00;
    end else if (!strapSeen_reg) begin
      strapSeen_reg <= 1'b1;
      refSel_reg    <= refSelStrap;
      bootSel_reg   <= bootStrapPins;
    end
  end

  // write channel: address and data taken in either order
  assign awready = !awHave_reg && !bvalid;
  assign wready  = !wHave_reg && !bvalid;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      awHave_reg <= 1'b0;
      wHave_reg  <= 1'b0;
      awAddr_reg <= 16'h0000;
      wData_reg  <= 32'h0000_0000;
    end else begin
      if (awvalid && awready) begin
        awHave_reg <= 1'b1;
        awAddr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        wHave_reg <= 1'b1;
        wData_reg <= {wstrb[3] ? wdata[31:24] : 8'h00, wstrb[2] ? wdata[23:16] : 8'h00,
                      wstrb[1] ? wdata[15:8] : 8'h00, wstrb[0] ? wdata[7:0] : 8'h00};
      end
      if (doWrite) begin
        awHave_reg <= 1'b0;
        wHave_reg  <= 1'b0;
      end
    end
  end
  assign doWrite = awHave_reg && wHave_reg && !bvalid;

  // rtc window is refused without its oscillator
  function automatic logic inRtc(input logic [15:0] a);
    inRtc = (a >= RtcWinLo) && (a <= RtcWinHi);
  endfunction

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp  <= AxiOkay;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      case (awAddr_reg)
        UsbSysCtrlOffs, GateAOffs, GateBOffs, SoftRstCntOffs, RstCtrlOffs, IdleCfgOffs,
        PllCtrlOffs: bresp <= AxiOkay;
        default: bresp <= (inRtc(awAddr_reg) && rtcOscPresent) ? AxiOkay : AxiSlvErr;
      endcase
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // software registers; all change only on clk_sys edges
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      usbCtrl_reg <= UsbSysCtrlReset;
      gateA_reg   <= GateReset;
      gateB_reg   <= GateReset;
      softCnt_reg <= 16'h0000;
      rstCtrl_reg <= 16'h0000;
      idle_reg    <= IdleReset;
      pllCtrl_reg <= 16'h0000;
    end else if (doWrite) begin
      case (awAddr_reg)
        UsbSysCtrlOffs: usbCtrl_reg <= wData_reg[15:0];
        GateAOffs:      gateA_reg   <= wData_reg[15:0];
        GateBOffs:      gateB_reg   <= wData_reg[15:0];
        SoftRstCntOffs: softCnt_reg <= wData_reg[15:0];
        RstCtrlOffs:    rstCtrl_reg <= wData_reg[15:0];
        IdleCfgOffs:    idle_reg    <= wData_reg[15:0];
        PllCtrlOffs:    pllCtrl_reg <= wData_reg[15:0];
        default:        ;
      endcase
    end
  end

  // reset control write loads the hold count; peripherals stay in reset until it runs out
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rstTimer_reg <= 16'h0000;
    end else if (doWrite && awAddr_reg == RstCtrlOffs) begin
      rstTimer_reg <= softCnt_reg;
    end else if (rstTimer_reg != 16'h0000) begin
      rstTimer_reg <= rstTimer_reg - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      periphResetAsserted <= 16'h0000;
      periphClkEnable     <= 32'h0000_0000;
      idleDomains         <= IdleReset;
    end else begin
      periphResetAsserted <= (rstTimer_reg != 16'h0000) ? rstCtrl_reg : 16'h0000;
      periphClkEnable     <= ~{gateB_reg, gateA_reg};
      idleDomains         <= idle_reg;
    end
  end

  // oscillator on: strap low forces it, else both disable bits clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      usbOscEnable <= 1'b0;
    end else if (!strapSeen_reg) begin
      usbOscEnable <= 1'b0;
    end else begin
      usbOscEnable <= !refSel_reg
        || (!usbCtrl_reg[UsbOscDisPos] && !usbCtrl_reg[UsbOscBiasDisPos]);
    end
  end

  // any pll control write reruns the lock interval on the bypass reference
  assign pllRestart = doWrite && (awAddr_reg == PllCtrlOffs);
  lock_timer #(
    .Cycles(LockCount)
  ) u_lock (
    .clk_sys(clk_sys),
    .rst_n  (rst_n),
    .restart(pllRestart),
    .done   (lockDone)
  );

  always_comb begin
    pll_next = pll_reg;
    case (pll_reg)
      PllBypass:  if (pllRestart && wData_reg[0]) pll_next = PllLocking;
      PllLocking: if (pllRestart && !wData_reg[0]) pll_next = PllBypass;
                  else if (lockDone && !pllRestart) pll_next = PllRunning;
      PllRunning: if (pllRestart) pll_next = wData_reg[0] ? PllLocking : PllBypass;
      default:    pll_next = PllBypass;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pll_reg <= PllBypass;
    end else begin
      pll_reg <= pll_next;
    end
  end

  assign sysClkFromPll    = (pll_reg == PllRunning);
  assign pllLocked        = lockDone;
  assign sysRefFromUsbOsc = !refSel_reg;
  assign extRefFreqSel    = bootSel_reg[5:4];
  assign rtcEnable        = rtcOscPresent;
  assign rtcSelect        = (arvalid && arready && inRtc(araddr) && rtcOscPresent);

  // read channel, one cycle after address accepted
  assign arready = !rvalid;
  always_comb begin
    rdErr = 1'b0;
    case (araddr)
      UsbSysCtrlOffs: rdVal = usbCtrl_reg;
      GateAOffs:      rdVal = gateA_reg;
      GateBOffs:      rdVal = gateB_reg;
      SoftRstCntOffs: rdVal = softCnt_reg;
      RstCtrlOffs:    rdVal = rstCtrl_reg;
      IdleCfgOffs:    rdVal = idle_reg;
      PllCtrlOffs:    rdVal = pllCtrl_reg;
      BootStrapOffs:  rdVal = {10'h000, bootSel_reg};
      ClkStatusOffs:  rdVal = {12'h000, usbOscEnable, refSel_reg, pllLocked, sysClkFromPll};
      default: begin
        rdVal = 16'h0000;
        rdErr = !(inRtc(araddr) && rtcOscPresent);
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= AxiOkay;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= {16'h0000, rdVal};
      rresp  <= rdErr ? AxiSlvErr : AxiOkay;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  osc_forced_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (strapSeen_reg && !refSel_reg) |=> usbOscEnable) else $error("osc off with strap low");
  osc_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (strapSeen_reg && refSel_reg && usbCtrl_reg[UsbOscDisPos]) |=> !usbOscEnable)
    else $error("osc on while disabled");
  pll_wait_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pllRestart |=> !sysClkFromPll) else $error("pll used before lock");
  rtc_refuse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (arvalid && arready && inRtc(araddr) && !rtcOscPresent) |=> (rvalid && rresp == AxiSlvErr))
    else $error("rtc read serviced without oscillator");
  boot_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    strapSeen_reg |=> $stable(bootSel_reg)) else $error("boot bits changed");
  gate_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (doWrite && awAddr_reg == GateAOffs) |=> ##1 (periphClkEnable[15:0] == ~gateA_reg))
    else $error("gate not applied");
  ref_path_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sysRefFromUsbOsc == !refSel_reg) else $error("reference path wrong");
  freq_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    extRefFreqSel == bootSel_reg[5:4]) else $error("freq select wrong");
  // a path that followed the pin after the latch would move the system reference mid-run
  ref_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    strapSeen_reg |=> $stable(sysRefFromUsbOsc)) else $error("reference path moved after latch");
  freq_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    strapSeen_reg |=> $stable(extRefFreqSel)) else $error("freq select moved after latch");
endmodule
`default_nettype wire

/* tb/strap_board_model.sv */
// board model: reference strap, boot strap pins and rtc oscillator
// assumes the bench sets the wanted levels; the strap follows them only while reset is held
`timescale 1ns/1ps
`default_nettype none
module strap_board_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       strapWanted,
  input  wire logic [5:0] bootWanted,
  input  wire logic       rtcWanted,
  output var logic        refSelStrap,
  output var logic [5:0]  bootStrapPins,
  output var logic        rtcOscPresent
);
  initial begin
    refSelStrap = 1'b1;
    bootStrapPins = 6'h00;
    rtcOscPresent = 1'b0;
  end
  always @(posedge clk_sys) begin
    // strap is tied on the board, so it only moves while the part sits in reset
    if (!rst_n) begin
      refSelStrap <= strapWanted;
    end
    // pins become plain gpio after boot and may move; the latch must not follow
    bootStrapPins <= bootWanted;
    // crystal fitted or not; its oscillator runs apart from the system reference
    rtcOscPresent <= rtcWanted;
  end
endmodule
`default_nettype wire

/* tb/system_clock_source_and_pll_control_test.sv */
// self-checking bench for the clock source and pll control block
// assumes the strap board model on the far side and an axi4-lite master in here
`timescale 1ns/1ps
`default_nettype none
module system_clock_source_and_pll_control_test
  import clk_src_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        strapWanted = 1'b1;
  logic [5:0]  bootWanted = 6'h2d;
  logic        rtcWanted = 1'b0;
  logic        refSelStrap, rtcOscPresent, sl;
  logic [5:0]  bootStrapPins;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
  logic [31:0] wdata = 32'h0, rd;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, usbOscEnable, sysRefFromUsbOsc;
  logic        sysClkFromPll, pllLocked, rtcEnable, rtcSelect;
  logic [1:0]  bresp, rresp, extRefFreqSel, rs;
  logic [31:0] rdata, periphClkEnable;
  logic [15:0] periphResetAsserted, idleDomains;
  int          err_total = 0, checks = 0, cycles = 0;

  always #50 clk_sys = ~clk_sys;

  strap_board_model strap_board_model_inst (.clk_sys(clk_sys), .rst_n(rst_n), .strapWanted(strapWanted),
    .bootWanted(bootWanted), .rtcWanted(rtcWanted), .refSelStrap(refSelStrap),
    .bootStrapPins(bootStrapPins), .rtcOscPresent(rtcOscPresent));

  // short lock count keeps the pll wait to about twenty cycles
  clk_src_ctrl #(.LockCount(20)) clk_src_ctrl_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .refSelStrap(refSelStrap), .bootStrapPins(bootStrapPins), .rtcOscPresent(rtcOscPresent),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .usbOscEnable(usbOscEnable), .sysRefFromUsbOsc(sysRefFromUsbOsc),
    .sysClkFromPll(sysClkFromPll), .pllLocked(pllLocked), .extRefFreqSel(extRefFreqSel),
    .rtcEnable(rtcEnable), .rtcSelect(rtcSelect), .periphClkEnable(periphClkEnable),
    .periphResetAsserted(periphResetAsserted), .idleDomains(idleDomains));

  task automatic summarize();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // waits end 1 ns past the edge so registered outputs have landed before a compare
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // handshake state is taken mid-cycle, where it equals what the next rising edge samples
  task automatic axiWrite(input logic [15:0] a, input logic [31:0] d);
    bit awOk, wOk, bOk;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bOk = 1'b0;
    while (!bOk) begin
      @(negedge clk_sys);
      awOk = awvalid && awready;
      wOk = wvalid && wready;
      bOk = bvalid && bready;
      rs = bresp;
      @(posedge clk_sys);
      if (awOk) awvalid <= 1'b0;
      if (wOk) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    #1;
  endtask

  task automatic axiRead(input logic [15:0] a);
    bit arOk, rOk;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rOk = 1'b0;
    sl = 1'b0;
    while (!rOk) begin
      @(negedge clk_sys);
      arOk = arvalid && arready;
      rOk = rvalid && rready;
      sl = sl | (arOk & rtcSelect);
      rd = rdata;
      rs = rresp;
      @(posedge clk_sys);
      if (arOk) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    #1;
  endtask

  task automatic doReset(input logic strap);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    strapWanted <= strap;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    tick(2);
  endtask

  task automatic testStrapHigh();
    check(32'(usbOscEnable), 32'h0);
    check(32'(sysRefFromUsbOsc), 32'h0);
    check(32'(extRefFreqSel), 32'h2);
    check(periphClkEnable, 32'h0);
    bootWanted = 6'h12;
    axiRead(BootStrapOffs);
    check({26'h0, rd[5:0]}, 32'h2d);
    axiRead(ClkStatusOffs);
    check({28'h0, rd[3:0]}, 32'h6);
    axiRead(UsbSysCtrlOffs);
    check(rd, 32'(UsbSysCtrlReset));
    axiRead(GateAOffs);
    check(rd, 32'(GateReset));
    axiWrite(BootStrapOffs, 32'h0);
    check(32'(rs), 32'(AxiSlvErr));
  endtask

  task automatic testUsbOsc();
    axiWrite(UsbSysCtrlOffs, 32'h1);
    tick(2);
    check(32'(usbOscEnable), 32'h0);
    axiWrite(UsbSysCtrlOffs, 32'h2);
    tick(2);
    check(32'(usbOscEnable), 32'h0);
    axiWrite(UsbSysCtrlOffs, 32'h0);
    // no usb setup follows here, so the start-up wait software owes the oscillator is not spent
    tick(2);
    check(32'(usbOscEnable), 32'h1);
  endtask

  task automatic testStrapLow();
    doReset(1'b0);
    check(32'(usbOscEnable), 32'h1);
    check(32'(sysRefFromUsbOsc), 32'h1);
    axiWrite(UsbSysCtrlOffs, 32'h3);
    tick(2);
    check(32'(usbOscEnable), 32'h1);
  endtask

  task automatic testRtc();
    tick(2);
    check(32'(rtcEnable), 32'h0);
    axiRead(RtcWinLo);
    check({29'h0, sl, rs}, {30'h0, AxiSlvErr});
    rtcWanted = 1'b1;
    tick(2);
    check(32'(rtcEnable), 32'h1);
    axiRead(RtcWinHi);
    check({29'h0, sl, rs}, {29'h1, AxiOkay});
    check(rd, 32'h0);
    axiRead(16'h1980);
    check(32'(rs), 32'(AxiSlvErr));
  endtask

  task automatic testPll();
    // only the use bit is written; reference, divider, vco and clock ranges stay software's
    axiWrite(PllCtrlOffs, 32'h1);
    check({30'h0, sysClkFromPll, pllLocked}, 32'h0);
    tick(10);
    check({30'h0, sysClkFromPll, pllLocked}, 32'h0);
    tick(15);
    check({30'h0, sysClkFromPll, pllLocked}, 32'h3);
    axiWrite(PllCtrlOffs, 32'h1);
    check({30'h0, sysClkFromPll, pllLocked}, 32'h0);
    axiWrite(PllCtrlOffs, 32'h0);
    tick(25);
    check({30'h0, sysClkFromPll, pllLocked}, 32'h1);
  endtask

  task automatic testGates();
    axiWrite(GateAOffs, 32'hfffe);
    axiWrite(GateBOffs, 32'h7fff);
    tick(2);
    check(periphClkEnable, 32'h80000001);
    axiWrite(SoftRstCntOffs, 32'h5);
    axiWrite(RstCtrlOffs, 32'h3);
    check(32'(periphResetAsserted), 32'h3);
    tick(4);
    check(32'(periphResetAsserted), 32'h3);
    tick(1);
    check(32'(periphResetAsserted), 32'h0);
    axiWrite(IdleCfgOffs, 32'hfffe);
    tick(2);
    check(32'(idleDomains), 32'hfffe);
  endtask

  // the whole run needs under two hundred cycles; the ceiling leaves wide margin
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    // nothing before the strap checks touches the pll or a timer, as boot settings must not
    doReset(1'b1);
    testStrapHigh();
    testUsbOsc();
    testRtc();
    testPll();
    testGates();
    testStrapLow();
    summarize();
  end
endmodule
`default_nettype wire
